// *** dv/frame_checker.sv ***
`timescale 1ns/1ps
module frame_checker (
  // Clock and reset
  input wire clk,
  input wire rst,
  input wire ce,
  // Inputs
  input wire [1:0] format_sel,
  input wire [15:0] rate_limit_div,
  input wire rate_set,
  input wire [15:0] rate_div,
  input wire freq_enable,
  input wire word_ready,
  // Outputs
  input wire rate_refused,
  input wire rate_accepted,
  input wire [15:0] current_div,
  input wire [16:0] max_rate,
  input wire [31:0] word_data,
  input wire [3:0] word_bytes,
  input wire word_valid,
  input wire word_last,
  input wire freq_out_p,
  input wire freq_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_refuse_zero: assert property (rate_set && ce && rate_div == 16'h0000 |=> rate_refused)
    else $error("zero divisor taken");
  a_refuse_limit: assert property (rate_set && ce && rate_div < rate_limit_div |=> rate_refused)
    else $error("divisor under limit taken");
  a_accept_div: assert property (rate_set && ce && rate_div >= 16'h0004 && rate_div >= rate_limit_div
    |=> rate_accepted && current_div == $past(rate_div)) else $error("divisor not taken");
  a_float_max: assert property ((ce && format_sel == 2'h2 && rate_limit_div == 16'h0000)[*3]
    |-> max_rate == 17'h0_2EE0) else $error("float limit wrong");
  a_twentyfour_bit_offset_format_max: assert property ((ce && format_sel == 2'h1 && rate_limit_div == 16'h0000)[*3]
    |-> max_rate == 17'h0_5DC0) else $error("twentyfour_bit_offset_format limit wrong");
  a_word_hold: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
    else $error("word dropped");
  a_word_width: assert property (word_valid |-> word_bytes == (format_sel == 2'h2 ? 4'h4 :
    format_sel == 2'h1 ? 4'h3 : 4'h2)) else $error("word width wrong");
  a_frame_end: assert property (word_valid && word_ready && ce && word_last |=> !word_valid)
    else $error("frame overran");
  a_freq_off: assert property (!freq_enable[*2] |-> !freq_out_p && !freq_out_n)
    else $error("square wave while off");
  c_refused: cover property (rate_refused);
  c_frame: cover property (word_valid && word_last && word_ready);
  c_freq: cover property (freq_enable && $rose(freq_out_p));
endmodule

// *** dv/host_sink.sv ***
`timescale 1ns/1ps
module host_sink (
  // Link
  input wire clk,
  input wire [2:0] stall,
  output reg word_ready = 1'b0
);
  // Random stalls prove each pending word is held
  always @(negedge clk) begin
    word_ready <= ($urandom % 8) >= stall;
  end
  // Integer words go up raw; the host applies user scaling itself
endmodule

// *** dv/measurement_frame_formatter_tb.sv ***
`timescale 1ns/1ps
module measurement_frame_formatter_tb;
  reg clk = 0, rst = 1, ce = 1, sample_valid = 0, rate_set = 0, freq_enable = 0;
  reg [191:0] samples = 0;
  reg [255:0] float_values = 0;
  reg [1:0] format_sel = 0;
  reg [15:0] rate_limit_div = 0, rate_div = 0, freq_scale = 16'h0100;
  reg [2:0] stall = 0;
  wire rate_refused, rate_accepted, word_valid, word_last, word_ready, fp, fn;
  wire [15:0] current_div;
  wire [16:0] max_rate;
  wire [31:0] word_data;
  wire [3:0] word_bytes;
  reg [36:0] exp_q[$];
  integer bad_count = 0, comparisons = 0, i;
  always #5 clk = ~clk;
  measurement_frame_formatter DUT (.clk, .rst, .ce, .samples, .float_values, .sample_valid,
    .format_sel, .rate_limit_div, .rate_set, .rate_div, .freq_enable, .freq_scale,
    .rate_refused, .rate_accepted, .current_div, .max_rate, .word_data, .word_bytes,
    .word_valid, .word_last, .word_ready, .freq_out_p(fp), .freq_out_n(fn));
  host_sink host (.clk, .stall, .word_ready);
  task automatic chk(input string n, input [36:0] e, s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task end_sim;
    $display("errors %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function [36:0] word(input integer c);
    reg [23:0] off;
    off = samples[24*c +: 24] ^ 24'h80_0000;
    case (format_sel)
      2'h0: word = {c == 7, 4'h2, 16'h0000, off[23:8]};
      2'h1: word = {c == 7, 4'h3, 8'h00, off};
      default: word = {c == 7, 4'h4, float_values[32*c +: 32]};
    endcase
  endfunction
  always @(posedge clk) if (!rst && ce && word_valid && word_ready) begin
    if (exp_q.size() == 0) chk("spare word", 0, 1);
    else chk("word", exp_q.pop_front(), {word_last, word_bytes, word_data});
  end
  // Repeating one sample n times frames it once whatever the divider phase
  task frame(input integer n, input [23:0] s1);
    samples = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    samples[71:0] = {24'h00_0000, 24'h7F_FFFF, s1};
    float_values = {samples, $urandom, $urandom};
    for (i = 0; i < 8; i++) exp_q.push_back(word(i));
    repeat (n) begin
      @(negedge clk) sample_valid = 1;
      @(negedge clk) sample_valid = 0;
      repeat (2) @(negedge clk);
      for (i = 0; i < 400 && word_valid !== 0; i++) @(negedge clk);
    end
    chk("frames left", 0, exp_q.size());
  endtask
  task rate(input [15:0] d, input ok, input [15:0] cd, input [16:0] mr);
    @(negedge clk) rate_div = d;
    rate_set = 1;
    @(negedge clk) rate_set = 0;
    chk("rate", {ok, !ok, cd, mr}, {rate_accepted, rate_refused, current_div, max_rate});
  endtask
  task meas(input [23:0] s, input [15:0] k, input integer mid);
    integer n;
    freq_scale = k;
    frame(6, s);
    repeat (3) begin
      n = 0;
      while (fp !== 0 && n < 5000) @(negedge clk) n++;
      while (fp !== 1 && n < 5000) @(negedge clk) n++;
    end
    chk("period", 1, n >= mid - 4 && n <= mid + 4);
  endtask
  initial begin
    void'($urandom(65));
    repeat (6) @(negedge clk);
    rst = 0;
    rate(16'h0000, 0, 16'h0004, 17'h0_BB80);
    rate(16'h0001, 1, 16'h0001, 17'h0_BB80);
    stall = 3;
    frame(1, 24'h80_0000);
    freq_scale = 16'h0200;
    frame(1, 24'h80_0000);
    format_sel = 1;
    rate(16'h0001, 0, 16'h0002, 17'h0_5DC0);
    rate(16'h0003, 1, 16'h0003, 17'h0_5DC0);
    frame(3, 24'h80_0000);
    format_sel = 2;
    rate(16'h0003, 0, 16'h0004, 17'h0_2EE0);
    frame(4, 24'h80_0000);
    rate_limit_div = 16'h0006;
    rate(16'h0005, 0, 16'h0006, 17'h0_1F40);
    rate(16'h0006, 1, 16'h0006, 17'h0_1F40);
    @(negedge clk) ce = 0;
    rate_div = 16'h0008;
    rate_set = 1;
    @(negedge clk) rate_set = 0;
    chk("frozen", {2'b00, 16'h0006}, {rate_accepted, rate_refused, current_div});
    ce = 1;
    rate_limit_div = 16'h0000;
    stall = 0;
    freq_enable = 1;
    meas(24'h00_0000, 16'h0100, 1667);
    meas(24'h79_E79E, 16'h0100, 1111);
    meas(24'h86_1862, 16'h0100, 3333);
    meas(24'h79_E79E, 16'h0200, 1093);
    meas(24'h86_1862, 16'h0200, 3509);
    freq_enable = 0;
    repeat (2) @(negedge clk);
    chk("freq off", 0, {fp, fn});
    end_sim;
  end
  initial begin
    #900_000;
    bad_count++;
    end_sim;
  end
endmodule
bind measurement_frame_formatter frame_checker chk_u (.clk, .rst, .ce, .format_sel,
  .rate_limit_div, .rate_set, .rate_div, .freq_enable, .word_ready, .rate_refused,
  .rate_accepted, .current_div, .max_rate, .word_data, .word_bytes, .word_valid,
  .word_last, .freq_out_p, .freq_out_n);

// *** hw/frame_map.vh ***
// Operation
// R1: Each frame holds all eight simultaneous samples
// R2: Sixteen-bit raw offset words, up to 48000/s
// R3: Twentyfour-bit raw offset words, at most 24000/s
// R4: Float scaled words, at most 12000/s
// R5: Sixteen-bit zero 0x8000, saturate 0x0000/0xFFFF
// R6: Twentyfour-bit zero 0x800000, negative saturates 0x000000
// R7: Host applies user scaling to integer values
// R8: Float values scaled by factor, matrix or RTD
// R9: Refuse frame rates above present maximum
// R10: Optional channel 1 frequency square wave
// R11: 60kHz zero, 90kHz positive, 30kHz negative
// R12: Clamp output between 28500Hz and 91500Hz
// R13: User scaling changes frequency mapping
// R14: Frame rate is 48000 over integer divisor
// R15: Report highest configurable frame rate on read
// R16: Frequency linear in scaled value before clamp
// R17: Channels in ascending order, format width each
`ifndef FRAME_MAP_VH
`define FRAME_MAP_VH
`define FMT_SIXTEEN_BIT_OFFSET_FORMAT 2'h0
`define FMT_TWENTYFOUR_BIT_OFFSET_FORMAT 2'h1
`define FMT_FLOAT 2'h2
`define BASE_RATE 17'h0_BB80
`define MAX_RATE_SIXTEEN_BIT_OFFSET_FORMAT 17'h0_BB80
`define MAX_RATE_TWENTYFOUR_BIT_OFFSET_FORMAT 17'h0_5DC0
`define MAX_RATE_FLOAT 17'h0_2EE0
`define MIN_DIV_SIXTEEN_BIT_OFFSET_FORMAT 16'h0001
`define MIN_DIV_TWENTYFOUR_BIT_OFFSET_FORMAT 16'h0002
`define MIN_DIV_FLOAT 16'h0004
`define ZERO_16 16'h8000
`define ZERO_24 24'h80_0000
`define CLK_HZ 32'h05F5_E100
`define FREQ_ZERO_HZ 32'h0000_EA60
`define FREQ_SPAN_HZ 32'h0000_7530
`define FREQ_MIN_HZ 32'h0000_6F54
`define FREQ_MAX_HZ 32'h0001_656C
`endif

// *** hw/freq_output.v ***
`timescale 1ns/1ps
`include "frame_map.vh"
module freq_output (
  // Clock and reset
  input wire clk,
  input wire rst,
  input wire ce,
  // Control
  input wire enable,
  input wire signed [23:0] sample,
  input wire sample_valid,
  input wire signed [15:0] user_scale,
  // Output pair
  output reg out_p,
  output reg out_n
);
  // Full scale is 0x79E79E counts from zero; scale is Q8.8
  localparam signed [31:0] FULL_SCALE = 32'sh0079_E79E;
  reg [31:0] freq_hz;
  reg [31:0] phase;
  reg signed [47:0] scaled;
  reg signed [47:0] delta;
  reg signed [47:0] target;
  wire [31:0] step = {freq_hz[30:0], 1'b0};
  wire [31:0] sum = phase + step;
  wire wrap = (sum >= `CLK_HZ);
  // Disable forces the pair low at once rather than at the next wrap
  wire next_out_p = enable & (wrap ? ~out_p : out_p);
  always @* begin
    scaled = (sample * user_scale) >>> 8; // R13
    delta = (scaled * $signed(`FREQ_SPAN_HZ)) / FULL_SCALE; // R16
    target = $signed({16'h0000, `FREQ_ZERO_HZ}) + delta; // R11
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      freq_hz <= `FREQ_ZERO_HZ;
      phase <= 32'h0000_0000;
      out_p <= 1'b0;
      out_n <= 1'b0;
    end else if (ce) begin
      if (sample_valid) begin
        if (target < $signed({16'h0000, `FREQ_MIN_HZ}))
          freq_hz <= `FREQ_MIN_HZ; // R12
        else if (target > $signed({16'h0000, `FREQ_MAX_HZ}))
          freq_hz <= `FREQ_MAX_HZ; // R12
        else
          freq_hz <= target[31:0];
      end
      // Toggle twice per period: step 2*f against the clock rate
      phase <= wrap ? sum - `CLK_HZ : sum;
      out_p <= next_out_p; // R10
      out_n <= enable & ~next_out_p; // R10
    end
  end
endmodule

// *** hw/measurement_frame_formatter.v ***
`timescale 1ns/1ps
`include "frame_map.vh"
module measurement_frame_formatter (
  // Clock and reset
  input wire clk,
  input wire rst,
  input wire ce,
  // Sample stream, eight signed 24-bit channels, channel 1 lowest
  input wire [191:0] samples,
  input wire [255:0] float_values,
  input wire sample_valid,
  // Configuration
  input wire [1:0] format_sel,
  input wire [15:0] rate_limit_div,
  input wire rate_set,
  input wire [15:0] rate_div,
  input wire freq_enable,
  input wire [15:0] freq_scale,
  // Rate control answers
  output reg rate_refused,
  output reg rate_accepted,
  output reg [15:0] current_div,
  output reg [16:0] max_rate,
  // Frame word stream
  output reg [31:0] word_data,
  output reg [3:0] word_bytes,
  output wire word_valid,
  output reg word_last,
  input wire word_ready,
  // Frequency output pair
  output wire freq_out_p,
  output wire freq_out_n
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;
  reg state;
  reg [15:0] dec_count;
  reg [2:0] chan;
  reg [255:0] frame_buf;
  reg [15:0] min_div;
  reg [15:0] eff_min;
  // Flat bus keeps each channel word on a single driver
  wire [255:0] enc;
  genvar g;
  // Offset binary: flip sign bit, keep the top 16 bits, saturate when the sample reaches +/-8388607
  generate
    for (g = 0; g < 8; g = g + 1) begin : conv
      wire signed [23:0] s = samples[24*g+23:24*g];
      wire [23:0] off24 = {~s[23], s[22:0]}; // R6
      reg [15:0] off16;
      reg [31:0] chan_word;
      assign enc[32*g+31:32*g] = chan_word;
      always @* begin
        off16 = off24[23:8]; // R5
        if (s <= -24'sd8388607)
          off16 = 16'h0000; // R5
        else if (s >= 24'sd8388607)
          off16 = 16'hFFFF; // R5
        if (format_sel == `FMT_FLOAT)
          chan_word = float_values[32*g+31:32*g]; // R8
        else if (format_sel == `FMT_TWENTYFOUR_BIT_OFFSET_FORMAT)
          chan_word = {8'h00, off24}; // R3
        else
          chan_word = {16'h0000, off16}; // R2
      end
    end
  endgenerate
  // Host learns limit before setting a rate; other features may raise the floor
  always @* begin
    case (format_sel)
      `FMT_TWENTYFOUR_BIT_OFFSET_FORMAT: min_div = `MIN_DIV_TWENTYFOUR_BIT_OFFSET_FORMAT; // R3
      `FMT_FLOAT: min_div = `MIN_DIV_FLOAT; // R4
      default: min_div = `MIN_DIV_SIXTEEN_BIT_OFFSET_FORMAT; // R2
    endcase
    eff_min = (rate_limit_div > min_div) ? rate_limit_div : min_div; // R9
  end
  assign word_valid = (state == ST_SEND);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      dec_count <= 16'h0000;
      chan <= 3'h0;
      frame_buf <= 256'h0;
      current_div <= `MIN_DIV_FLOAT;
      rate_refused <= 1'b0;
      rate_accepted <= 1'b0;
      max_rate <= `MAX_RATE_SIXTEEN_BIT_OFFSET_FORMAT;
      word_data <= 32'h0000_0000;
      word_bytes <= 4'h0;
      word_last <= 1'b0;
    end else if (ce) begin
      rate_refused <= 1'b0;
      rate_accepted <= 1'b0;
      max_rate <= `BASE_RATE / {1'b0, eff_min}; // R15
      if (rate_set) begin
        if (rate_div == 16'h0000 || rate_div < eff_min) begin
          rate_refused <= 1'b1; // R9
        end else begin
          current_div <= rate_div; // R14
          rate_accepted <= 1'b1;
        end
      end else if (current_div < eff_min) begin
        current_div <= eff_min; // R9
      end
      case (state)
        ST_IDLE: begin
          if (sample_valid) begin
            if (dec_count + 16'h0001 >= current_div) begin // R14
              dec_count <= 16'h0000;
              frame_buf <= enc; // R1
              word_data <= enc[31:0];
              word_bytes <= (format_sel == `FMT_FLOAT) ? 4'h4 :
                            (format_sel == `FMT_TWENTYFOUR_BIT_OFFSET_FORMAT) ? 4'h3 : 4'h2;
              chan <= 3'h0;
              word_last <= 1'b0;
              state <= ST_SEND;
            end else begin
              dec_count <= dec_count + 16'h0001;
            end
          end
        end
        ST_SEND: begin
          // Samples arriving mid-frame are counted but not framed
          if (sample_valid)
            dec_count <= dec_count + 16'h0001;
          if (word_ready) begin
            if (chan == 3'h7) begin
              state <= ST_IDLE;
            end else begin
              chan <= chan + 3'h1; // R17
              word_data <= frame_buf[32*(chan+1)+:32]; // R17
              word_last <= (chan == 3'h6);
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  freq_output u_freq (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .enable(freq_enable),
    .sample(samples[23:0]),
    .sample_valid(sample_valid),
    .user_scale(freq_scale),
    .out_p(freq_out_p),
    .out_n(freq_out_n)
  );
endmodule
